/* sim/ipc_regs_bench.sv */
// Self-checking bench for the input loop register bank.
// Assumes ipc_pkg and ipc_defs.svh are compiled with the design.
`timescale 1ns/10ps
`default_nettype none
`include "ipc_defs.svh"

module ipc_regs_bench
    import ipc_pkg::*;
;
    localparam int LIMIT = 20000;

    logic          ref_clk = 1'b0;
    logic          nrst = 1'b0;
    logic          ce = 1'b0;
    logic          reg_wr = 1'b0;
    logic          reg_rd = 1'b0;
    logic [11:0]   reg_addr = 12'h000;
    logic [7:0]    reg_wdata = 8'h00;
    logic          sec_independent = 1'b0;
    logic          pri_se_neg_sel = 1'b0;
    logic          sec_se_neg_sel = 1'b0;
    logic [7:0]    reg_rdata;
    logic          reg_rvalid;
    logic [15:0]   user_version_tag;
    logic [9:0]    primary_ratio, secondary_ratio, loop_feedback_ratio;
    logic [5:0]    test_ratio;
    logic [6:0]    cp_current_code;
    logic          cp_tristate, cp_pump_up, cp_pump_down, cp_normal;
    logic          backlash_auto;
    ipc_ab_width_t backlash_width;
    logic          test_rx_en, primary_rx_en, secondary_rx_en;
    logic          primary_rx_diff, secondary_rx_diff;
    logic          primary_rx_neg_pin, secondary_rx_neg_pin;
    logic          osc_rx_diff, osc_rx_neg_pin;
    logic [15:0]   pump_vec, rx_vec;
    int            bad_count = 0;
    int            n_tests = 0;
    int            cyc = 0;
    logic [11:0]   amap [14] = '{12'h005, 12'h006, 12'h010, 12'h011,
        12'h012, 12'h013, 12'h014, 12'h015, 12'h016, 12'h017, 12'h018,
        12'h019, 12'h01a, 12'h020};
    logic [9:0]    codes [4] = '{10'h000, 10'h001, 10'h002, 10'h3ff};

    assign pump_vec = {12'h000, cp_tristate, cp_pump_up, cp_pump_down,
                       cp_normal};
    assign rx_vec = {7'h00, test_rx_en, primary_rx_en, secondary_rx_en,
                     primary_rx_diff, secondary_rx_diff, primary_rx_neg_pin,
                     secondary_rx_neg_pin, osc_rx_diff, osc_rx_neg_pin};

    ipc_regs ipc_regs_i (
        .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .sec_independent(sec_independent), .pri_se_neg_sel(pri_se_neg_sel),
        .sec_se_neg_sel(sec_se_neg_sel), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .user_version_tag(user_version_tag),
        .primary_ratio(primary_ratio), .secondary_ratio(secondary_ratio),
        .test_ratio(test_ratio), .loop_feedback_ratio(loop_feedback_ratio),
        .cp_current_code(cp_current_code), .cp_tristate(cp_tristate),
        .cp_pump_up(cp_pump_up), .cp_pump_down(cp_pump_down),
        .cp_normal(cp_normal), .backlash_auto(backlash_auto),
        .backlash_width(backlash_width), .test_rx_en(test_rx_en),
        .primary_rx_en(primary_rx_en), .secondary_rx_en(secondary_rx_en),
        .primary_rx_diff(primary_rx_diff),
        .secondary_rx_diff(secondary_rx_diff),
        .primary_rx_neg_pin(primary_rx_neg_pin),
        .secondary_rx_neg_pin(secondary_rx_neg_pin),
        .osc_rx_diff(osc_rx_diff), .osc_rx_neg_pin(osc_rx_neg_pin)
    );

    always #2 ref_clk = ~ref_clk;

    task automatic close_out();
        $display("counts: checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // A hung handshake lands here rather than running forever
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            bad_count++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Drives land on a rising edge; the request is taken at the next one.
    // Strobe stays up so back-to-back writes need no gap
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
    endtask

    task automatic idle();
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    // Outputs lag the registers by an extra edge, so wait two; look mid-cycle
    task automatic flush();
        idle();
        idle();
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        while (reg_rvalid !== 1'b1 && n < 3)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk({15'h0000, reg_rvalid}, 16'h0001);
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    function automatic logic [15:0] eff(input logic [15:0] c);
        return (c < 16'h0002) ? 16'h0001 : c;
    endfunction

    function automatic logic [15:0] rx_exp(input logic [7:0] v,
                                           input logic [1:0] s);
        return {7'h00, v[7], !v[2] | v[3], !v[2] | v[4], v[5], v[6],
                !v[5] & s[0], !v[6] & s[1], v[0], !v[0] & v[1]};
    endfunction

    initial
    begin : main
        logic [9:0] c;
        logic [9:0] c2;
        logic [5:0] k;
        logic [9:0] j;
        logic       tri_on;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        ce   <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(user_version_tag, 16'h0000);
        chk({primary_ratio, test_ratio}, {10'h001, 6'h01});
        chk({6'h00, secondary_ratio}, 16'h0001);
        chk({6'h00, loop_feedback_ratio}, 16'h0001);
        chk(pump_vec, 16'h0008);
        chk({13'h0000, backlash_auto, backlash_width}, 16'h0004);
        chk(rx_vec, rx_exp(8'h00, 2'b00));
        for (int i = 0; i < 14; i++)
            rd(amap[i], 8'h00);
        $display("test reset done");

        wr(`IPC_A_TAG_LO, 8'ha5);
        wr(`IPC_A_TAG_HI, 8'h3c);
        flush();
        chk(user_version_tag, 16'h3ca5);
        chk(pump_vec, 16'h0008);
        rd(`IPC_A_TAG_HI, 8'h3c);
        $display("test tag done");

        @(posedge ref_clk);
        sec_independent <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            c  = codes[i];
            c2 = codes[3 - i];
            wr(`IPC_A_PRI_LO, c[7:0]);
            wr(`IPC_A_PRI_HI, {6'h3f, c[9:8]});
            wr(`IPC_A_SEC_LO, c2[7:0]);
            wr(`IPC_A_SEC_HI, {6'h3f, c2[9:8]});
            wr(`IPC_A_FB_LO, c[7:0]);
            wr(`IPC_A_FB_HI, {6'h3f, c[9:8]});
            wr(`IPC_A_TEST, {2'b11, c[5:0]});
            flush();
            chk({6'h00, primary_ratio}, eff({6'h00, c}));
            chk({6'h00, secondary_ratio}, eff({6'h00, c2}));
            chk({6'h00, loop_feedback_ratio}, eff({6'h00, c}));
            chk({10'h000, test_ratio}, eff({10'h000, c[5:0]}));
            rd(`IPC_A_PRI_HI, {6'h00, c[9:8]});
            rd(`IPC_A_TEST, {2'b00, c[5:0]});
        end
        @(posedge ref_clk);
        sec_independent <= 1'b0;
        flush();
        chk({6'h00, secondary_ratio}, 16'h03ff);
        $display("test dividers done");

        for (int i = 0; i < 64; i++)
        begin
            k = i[5:0];
            tri_on = k[5] | (k[1:0] == 2'b00);
            wr(`IPC_A_CP, {k[5], k[5:0], k[0]});
            wr(`IPC_A_MODE, {3'b111, k[4:0]});
            flush();
            chk(pump_vec, {12'h000, tri_on, !tri_on & (k[1:0] == 2'b01),
                !tri_on & (k[1:0] == 2'b10),
                !tri_on & (k[1:0] == 2'b11)});
            chk({9'h000, cp_current_code}, {9'h000, k[5:0], k[0]});
            chk({13'h0000, backlash_auto, backlash_width},
                {13'h0000, !k[4], k[4] ? k[3:2] : 2'b00});
            rd(`IPC_A_MODE, {3'b000, k[4:0]});
            rd(`IPC_A_CP, {k[5], k[5:0], k[0]});
        end
        $display("test pump done");

        for (int i = 0; i < 1024; i++)
        begin
            j = i[9:0];
            @(posedge ref_clk);
            pri_se_neg_sel <= j[8];
            sec_se_neg_sel <= j[9];
            wr(`IPC_A_RX, j[7:0]);
            flush();
            chk(rx_vec,
                rx_exp(j[7:0], j[9:8]));
            rd(`IPC_A_RX, j[7:0]);
        end
        $display("test receivers done");

        wr(`IPC_A_RSVD, 8'hff);
        wr(12'h020, 8'hff);
        flush();
        rd(`IPC_A_RSVD, 8'h00);
        rd(12'h020, 8'h00);
        @(posedge ref_clk);
        ce <= 1'b0;
        wr(`IPC_A_TAG_LO, 8'h11);
        idle();
        ce <= 1'b1;
        flush();
        rd(`IPC_A_TAG_LO, 8'ha5);
        chk(user_version_tag, 16'h3ca5);
        $display("test reserved and enable done");
        close_out();
    end
endmodule

`default_nettype wire

/* src/ipc_defs.svh */
// Offsets, field positions and reset values of the input loop bank.
// Assumes 12-bit byte addresses on the serial register port.
`ifndef IPC_DEFS_SVH
`define IPC_DEFS_SVH

`define IPC_AW            12
`define IPC_A_TAG_LO      12'h005
`define IPC_A_TAG_HI      12'h006
`define IPC_A_PRI_LO      12'h010
`define IPC_A_PRI_HI      12'h011
`define IPC_A_SEC_LO      12'h012
`define IPC_A_SEC_HI      12'h013
`define IPC_A_TEST        12'h014
`define IPC_A_RSVD        12'h015
`define IPC_A_FB_LO       12'h016
`define IPC_A_FB_HI       12'h017
`define IPC_A_CP          12'h018
`define IPC_A_MODE        12'h019
`define IPC_A_RX          12'h01a

`define IPC_CP_TRI_BIT    7
`define IPC_AB_OVR_BIT    4
`define IPC_AB_MSB        3
`define IPC_AB_LSB        2
`define IPC_RX_TEST_BIT   7
`define IPC_RX_SEC_DIFF   6
`define IPC_RX_PRI_DIFF   5
`define IPC_RX_SEC_EN     4
`define IPC_RX_PRI_EN     3
`define IPC_RX_PD_CTL     2
`define IPC_RX_OSC_NEG    1
`define IPC_RX_OSC_DIFF   0

`define IPC_RST_BYTE      8'h00
`define IPC_RST_HI2       2'h0
`define IPC_RST_TEST      6'h00
`define IPC_RST_MODE      5'h00

`endif

/* src/ipc_pkg.sv */
// Types shared by the input loop register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package ipc_pkg;

    typedef enum logic [1:0] {
        IPC_CP_TRISTATE = 2'b00,
        IPC_CP_UP       = 2'b01,
        IPC_CP_DOWN     = 2'b10,
        IPC_CP_NORMAL   = 2'b11
    } ipc_cp_mode_t;

    typedef enum logic [1:0] {
        IPC_AB_MIN  = 2'b00,
        IPC_AB_LOW  = 2'b01,
        IPC_AB_HIGH = 2'b10,
        IPC_AB_MAX  = 2'b11
    } ipc_ab_width_t;

endpackage

/* src/ipc_regs.sv */
// Input loop configuration bank: divider ratios, charge pump and
// receiver controls. Assumes a synchronous byte-wide register port
// driven by the serial control logic; bits held in neighbouring
// registers arrive as plain inputs.
`timescale 1ns/10ps
`default_nettype none
`include "ipc_defs.svh"

// Function
// - Sixteen-bit user tag in two bytes, low first, resets zero, inert.
// - Primary divider ratio is ten bits over two registers; 0 and 1 mean 1.
// - Secondary divider has its own ten-bit ratio; 0 and 1 mean 1.
// - Secondary uses its own ratio only when the independence bit is set.
// - Test divider ratio is six bits, 1 to 63; top two bits reserved.
// - Feedback divider ratio is ten bits over two registers; 0,1 mean 1.
// - Charge pump tristate bit forces the pump output into tristate.
// - Seven-bit code sets charge pump current in half-microamp steps.
// - Override bit clear means automatic antibacklash period, else field.
// - Width field 00 min, 01 low, 10 high, 11 max; needs override.
// - Pump mode 00 tristate, 01 up, 10 down, 11 normal.
// - Test receiver enabled when its bit is set; disabled after reset.
// - Reference diff bits set differential, else single-ended by pin select.
// - Power-down control clear keeps both reference receivers enabled.
// - With power-down control, enable bits power receivers up or down.
// - Oscillator receiver differential bit; else pin bit picks neg or pos.
module ipc_regs
    import ipc_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    input  wire logic          ce,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [11:0]   reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          sec_independent,
    input  wire logic          pri_se_neg_sel,
    input  wire logic          sec_se_neg_sel,
    output logic [7:0]         reg_rdata,
    output logic               reg_rvalid,
    output logic [15:0]        user_version_tag,
    output logic [9:0]         primary_ratio,
    output logic [9:0]         secondary_ratio,
    output logic [5:0]         test_ratio,
    output logic [9:0]         loop_feedback_ratio,
    output logic [6:0]         cp_current_code,
    output logic               cp_tristate,
    output logic               cp_pump_up,
    output logic               cp_pump_down,
    output logic               cp_normal,
    output logic               backlash_auto,
    output ipc_ab_width_t      backlash_width,
    output logic               test_rx_en,
    output logic               primary_rx_en,
    output logic               secondary_rx_en,
    output logic               primary_rx_diff,
    output logic               secondary_rx_diff,
    output logic               primary_rx_neg_pin,
    output logic               secondary_rx_neg_pin,
    output logic               osc_rx_diff,
    output logic               osc_rx_neg_pin
);

    // Zero and one both divide by one
    function automatic logic [9:0] eff10(input logic [9:0] c);
        eff10 = (c < 10'h002) ? 10'h001 : c;
    endfunction

    function automatic logic [5:0] eff6(input logic [5:0] c);
        eff6 = (c < 6'h02) ? 6'h01 : c;
    endfunction

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] b);
        hit = (a == b);
    endfunction

    logic [15:0] tag_q;
    logic [7:0]  pri_lo_q;
    logic [1:0]  pri_hi_q;
    logic [7:0]  sec_lo_q;
    logic [1:0]  sec_hi_q;
    logic [5:0]  test_q;
    logic [7:0]  fb_lo_q;
    logic [1:0]  fb_hi_q;
    logic [7:0]  cp_q;
    logic [4:0]  mode_q;
    logic [7:0]  rx_q;
    logic [7:0]  rdata_d;
    logic        wen;
    logic [9:0]  pri_eff;
    logic [9:0]  sec_eff;
    logic [1:0]  pmode;

    assign wen     = ce && reg_wr;
    assign pri_eff = eff10({pri_hi_q, pri_lo_q});
    assign sec_eff = eff10({sec_hi_q, sec_lo_q});
    assign pmode   = mode_q[1:0];

    // Storage; narrow fields drop reserved write bits
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tag_q    <= {`IPC_RST_BYTE, `IPC_RST_BYTE};
            pri_lo_q <= `IPC_RST_BYTE;
            pri_hi_q <= `IPC_RST_HI2;
            sec_lo_q <= `IPC_RST_BYTE;
            sec_hi_q <= `IPC_RST_HI2;
            test_q   <= `IPC_RST_TEST;
            fb_lo_q  <= `IPC_RST_BYTE;
            fb_hi_q  <= `IPC_RST_HI2;
            cp_q     <= `IPC_RST_BYTE;
            mode_q   <= `IPC_RST_MODE;
            rx_q     <= `IPC_RST_BYTE;
        end
        else if (wen)
        begin
            if (hit(reg_addr, `IPC_A_TAG_LO))
                tag_q[7:0] <= reg_wdata;
            if (hit(reg_addr, `IPC_A_TAG_HI))
                tag_q[15:8] <= reg_wdata;
            if (hit(reg_addr, `IPC_A_PRI_LO))
                pri_lo_q <= reg_wdata;
            if (hit(reg_addr, `IPC_A_PRI_HI))
                pri_hi_q <= reg_wdata[1:0];
            if (hit(reg_addr, `IPC_A_SEC_LO))
                sec_lo_q <= reg_wdata;
            if (hit(reg_addr, `IPC_A_SEC_HI))
                sec_hi_q <= reg_wdata[1:0];
            if (hit(reg_addr, `IPC_A_TEST))
                test_q <= reg_wdata[5:0];
            if (hit(reg_addr, `IPC_A_FB_LO))
                fb_lo_q <= reg_wdata;
            if (hit(reg_addr, `IPC_A_FB_HI))
                fb_hi_q <= reg_wdata[1:0];
            if (hit(reg_addr, `IPC_A_CP))
                cp_q <= reg_wdata;
            if (hit(reg_addr, `IPC_A_MODE))
                mode_q <= reg_wdata[4:0];
            if (hit(reg_addr, `IPC_A_RX))
                rx_q <= reg_wdata;
        end
    end

    // Read mux; unmapped and reserved locations give zero
    always_comb
    begin
        case (reg_addr)
            `IPC_A_TAG_LO: rdata_d = tag_q[7:0];
            `IPC_A_TAG_HI: rdata_d = tag_q[15:8];
            `IPC_A_PRI_LO: rdata_d = pri_lo_q;
            `IPC_A_PRI_HI: rdata_d = {6'h00, pri_hi_q};
            `IPC_A_SEC_LO: rdata_d = sec_lo_q;
            `IPC_A_SEC_HI: rdata_d = {6'h00, sec_hi_q};
            `IPC_A_TEST:   rdata_d = {2'h0, test_q};
            `IPC_A_FB_LO:  rdata_d = fb_lo_q;
            `IPC_A_FB_HI:  rdata_d = {6'h00, fb_hi_q};
            `IPC_A_CP:     rdata_d = cp_q;
            `IPC_A_MODE:   rdata_d = {3'h0, mode_q};
            `IPC_A_RX:     rdata_d = rx_q;
            default:       rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else if (ce)
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rdata_d;
        end
    end

    // Tag is kept only for software; nothing else reads it
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            user_version_tag <= 16'h0000;
        else if (ce)
            user_version_tag <= tag_q;
    end

    // Effective divider ratios, one cycle behind the registers
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            primary_ratio       <= 10'h001;
            secondary_ratio     <= 10'h001;
            test_ratio          <= 6'h01;
            loop_feedback_ratio <= 10'h001;
        end
        else if (ce)
        begin
            primary_ratio <= pri_eff;
            // Without independence the secondary tracks the primary
            secondary_ratio <= sec_independent ? sec_eff
                                               : pri_eff;
            test_ratio <= eff6(test_q);
            loop_feedback_ratio <= eff10({fb_hi_q, fb_lo_q});
        end
    end

    // Charge pump: tristate bit overrides any mode
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cp_current_code <= 7'h00;
            cp_tristate     <= 1'b1;
            cp_pump_up      <= 1'b0;
            cp_pump_down    <= 1'b0;
            cp_normal       <= 1'b0;
        end
        else if (ce)
        begin
            cp_current_code <= cp_q[6:0];
            cp_tristate <= cp_q[`IPC_CP_TRI_BIT] ||
                           (pmode == IPC_CP_TRISTATE);
            cp_pump_up <= !cp_q[`IPC_CP_TRI_BIT] &&
                          (pmode == IPC_CP_UP);
            cp_pump_down <= !cp_q[`IPC_CP_TRI_BIT] &&
                            (pmode == IPC_CP_DOWN);
            cp_normal <= !cp_q[`IPC_CP_TRI_BIT] &&
                         (pmode == IPC_CP_NORMAL);
        end
    end

    // Width is shown as minimum while automatic, since it is unused then
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            backlash_auto  <= 1'b1;
            backlash_width <= IPC_AB_MIN;
        end
        else if (ce)
        begin
            backlash_auto <= !mode_q[`IPC_AB_OVR_BIT];
            backlash_width <= mode_q[`IPC_AB_OVR_BIT]
                ? ipc_ab_width_t'(mode_q[`IPC_AB_MSB:`IPC_AB_LSB])
                : IPC_AB_MIN;
        end
    end

    // Receivers; reset state has power-down control off, so both run
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            test_rx_en           <= 1'b0;
            primary_rx_en        <= 1'b1;
            secondary_rx_en      <= 1'b1;
            primary_rx_diff      <= 1'b0;
            secondary_rx_diff    <= 1'b0;
            primary_rx_neg_pin   <= 1'b0;
            secondary_rx_neg_pin <= 1'b0;
            osc_rx_diff          <= 1'b0;
            osc_rx_neg_pin       <= 1'b0;
        end
        else if (ce)
        begin
            test_rx_en <= rx_q[`IPC_RX_TEST_BIT];
            primary_rx_en <= !rx_q[`IPC_RX_PD_CTL] ||
                             rx_q[`IPC_RX_PRI_EN];
            secondary_rx_en <= !rx_q[`IPC_RX_PD_CTL] ||
                               rx_q[`IPC_RX_SEC_EN];
            primary_rx_diff <= rx_q[`IPC_RX_PRI_DIFF];
            secondary_rx_diff <= rx_q[`IPC_RX_SEC_DIFF];
            primary_rx_neg_pin <= !rx_q[`IPC_RX_PRI_DIFF] &&
                                  pri_se_neg_sel;
            secondary_rx_neg_pin <= !rx_q[`IPC_RX_SEC_DIFF] &&
                                    sec_se_neg_sel;
            osc_rx_diff <= rx_q[`IPC_RX_OSC_DIFF];
            osc_rx_neg_pin <= !rx_q[`IPC_RX_OSC_DIFF] &&
                              rx_q[`IPC_RX_OSC_NEG];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_wr_tag_hi;
        ce && reg_wr && reg_addr == `IPC_A_TAG_HI;
    endsequence

    sequence s_rd_rsvd;
        ce && reg_rd && reg_addr == `IPC_A_RSVD;
    endsequence

    a_tag_high_write: assert property (
        s_wr_tag_hi ##1 ce |=>
            user_version_tag[15:8] == $past(reg_wdata, 2))
        else $error("tag high byte not taken");

    a_pri_ratio_eff: assert property (
        $past(ce) |-> primary_ratio ==
            eff10($past({pri_hi_q, pri_lo_q})))
        else $error("primary ratio wrong");

    a_ratio_not_zero: assert property (
        primary_ratio != 10'h000 && loop_feedback_ratio != 10'h000)
        else $error("ratio of zero shown");

    a_sec_ratio_sel: assert property (
        $past(ce) |-> secondary_ratio == ($past(sec_independent)
            ? eff10($past({sec_hi_q, sec_lo_q}))
            : eff10($past({pri_hi_q, pri_lo_q}))))
        else $error("secondary ratio source wrong");

    a_test_ratio_eff: assert property (
        $past(ce) |-> test_ratio == eff6($past(test_q)))
        else $error("test ratio wrong");

    a_fb_ratio_eff: assert property (
        $past(ce) |-> loop_feedback_ratio ==
            eff10($past({fb_hi_q, fb_lo_q})))
        else $error("feedback ratio wrong");

    a_cp_tristate_force: assert property (
        $past(ce) && $past(cp_q[`IPC_CP_TRI_BIT]) |->
            cp_tristate && !cp_pump_up && !cp_pump_down && !cp_normal)
        else $error("pump not tristated");

    a_cp_one_mode: assert property (
        $onehot({cp_tristate, cp_pump_up, cp_pump_down, cp_normal}))
        else $error("pump mode not one-hot");

    a_cp_current_code: assert property (
        $past(ce) |-> cp_current_code == $past(cp_q[6:0]))
        else $error("pump current code wrong");

    a_backlash_auto: assert property (
        $past(ce) && !$past(mode_q[`IPC_AB_OVR_BIT]) |->
            backlash_auto && backlash_width == IPC_AB_MIN)
        else $error("antibacklash not automatic");

    a_rx_power_ctl: assert property (
        $past(ce) && !$past(rx_q[`IPC_RX_PD_CTL]) |->
            primary_rx_en && secondary_rx_en)
        else $error("receiver powered down without control");

    a_osc_pin_sel: assert property (
        osc_rx_diff |-> !osc_rx_neg_pin)
        else $error("pin select while differential");

    a_rsvd_read_zero: assert property (
        s_rd_rsvd |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("reserved register not zero");

endmodule
`default_nettype wire
